// ---- logic/sdcr_pkg.sv ----
// Shared constants, frame helpers and card data layout for the SD card register link
package sdcr_pkg;

  // Command line frame
  localparam int          FRAME_BITS   = 48;
  localparam logic [5:0]  CNT_FRAME    = 6'h30;
  localparam logic [5:0]  CNT_LAST     = 6'h2f;
  localparam logic        DIR_HOST     = 1'b1;
  localparam logic        DIR_CARD     = 1'b0;
  localparam logic        CMD_RELEASED = 1'b1;

  // Command indices
  localparam logic [5:0]  IDX_SET_RCA      = 6'h03;
  localparam logic [5:0]  IDX_DRIVER_STAGE = 6'h04;
  localparam logic [5:0]  IDX_READ_CSD     = 6'h09;
  localparam logic [5:0]  IDX_INACTIVE     = 6'h0f;
  localparam logic [5:0]  IDX_PROGRAM_CSD  = 6'h1b;
  localparam logic [5:0]  IDX_ERASE        = 6'h26;

  // Argument and status fields
  localparam int          ARG_SEL_HIGH_BIT   = 0;
  localparam int          ARG_RCA_LSB        = 16;
  localparam logic [31:0] ERASE_ONE_BLOCK    = 32'h0000_0001;
  localparam logic [31:0] STAT_ERASE_REFUSED = 32'h0800_0000;

  // Card data register, low 48 bits
  localparam int          CSD_ERASE_BIT  = 46;
  localparam int          CSD_SECTOR_LSB = 39;
  localparam int          CSD_R2W_LSB    = 26;
  localparam int          CSD_WBL_LSB    = 22;
  localparam int          CSD_WPART_BIT  = 21;
  localparam int          CSD_FFG_BIT    = 15;
  localparam int          CSD_COPY_BIT   = 14;
  localparam int          CSD_PERM_BIT   = 13;
  localparam int          CSD_TMP_BIT    = 12;
  localparam int          CSD_FF_LSB     = 10;
  localparam int          CSD_CRC_LSB    = 1;
  localparam int          CSD_END_BIT    = 0;
  localparam int          ERASE_IN_HIGH  = CSD_ERASE_BIT - 32;
  localparam logic        ERASE_BLOCK_ENABLE_VAL = 1'b0;
  localparam logic [6:0]  SECTOR_SIZE_VAL  = 7'h7f;
  localparam logic [2:0]  R2W_VAL          = 3'h2;
  localparam logic [3:0]  WRITE_BL_LEN_VAL = 4'h9;
  localparam logic        WPART_VAL        = 1'b0;
  localparam logic        FFG_VAL          = 1'b0;
  localparam logic [1:0]  FIELD_A_VAL  = 2'h0;
  localparam logic        END_BIT_VAL      = 1'b1;

  // Reset values
  localparam logic [15:0] RCA_RESET   = 16'h0000;
  localparam logic        COPY_RESET  = 1'b0;
  localparam logic        PERM_RESET  = 1'b0;
  localparam logic        TMP_RESET   = 1'b0;

  // Cycle counts
  localparam logic [2:0]  LINK_HALF_LAST = 3'h7;
  localparam logic [6:0]  INIT_LAST      = 7'h49;
  localparam logic [5:0]  NCR_LAST       = 6'h01;
  localparam logic [6:0]  RSP_TIMEOUT    = 7'h40;

  function automatic logic [6:0] crc7(input logic [39:0] d);
    logic [6:0] c;
    logic       fb;
    c = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      fb = d[i] ^ c[6];
      c  = {c[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
    end
    return c;
  endfunction : crc7

  function automatic logic [47:0] make_frame(input logic dir, input logic [5:0] idx, input logic [31:0] arg);
    return {1'b0, dir, idx, arg, crc7({1'b0, dir, idx, arg}), END_BIT_VAL};
  endfunction : make_frame

  function automatic logic frame_ok(input logic [47:0] f, input logic dir);
    return (f[47] == 1'b0) && (f[46] == dir) && (f[0] == END_BIT_VAL) && (f[7:1] == crc7(f[47:8]));
  endfunction : frame_ok

endpackage : sdcr_pkg

// ---- logic/sdcr_link_if.sv ----
// Card bus between host and card: link clock and shared command line
`timescale 1ns/1ps
interface sdcr_link_if;
  logic link_clk;
  logic cmd_host_o;
  logic cmd_host_oe;
  logic cmd_dev_o;
  logic cmd_dev_oe;
  logic cmd;

  // Pull-up when nobody drives; host wins a clash
  assign cmd = cmd_host_oe ? cmd_host_o : (cmd_dev_oe ? cmd_dev_o : sdcr_pkg::CMD_RELEASED);

  modport host (
    output link_clk,
    output cmd_host_o,
    output cmd_host_oe,
    input  cmd
  );

  modport device (
    input  link_clk,
    input  cmd,
    output cmd_dev_o,
    output cmd_dev_oe
  );
endinterface : sdcr_link_if

// ---- logic/sdcr_device.sv ----
// Card end: command receiver, card registers and response sender
// Functional notes
// - Single-block erase refused, reported in data field
// - Host reads erase field before single erase
// - Writable 16-bit relative card address register
// - Driver-stage register absent, accesses have no effect
// - Copy, permanent protect reset 0, program once
// - Temporary protect resets 0, freely rewritable
// - Format group, format, bits 9:8 read zero
// - CRC7 in bits 7:1, bit 0 one
// - Partial write flag and bits 20:16 zero
// - Host gives 74 clocks, command high, first
// - Inactive card ignores all until power cycle
// - Host releases or lowers lines at power-down
`timescale 1ns/1ps
module sdcr_device (
  // Clock and power-on reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Card bus
  sdcr_link_if.device      link,
  // Card state
  output logic [15:0]      rca_out,
  output logic             copy_out,
  output logic             perm_protect_out,
  output logic             tmp_protect_out,
  output logic             inactive_out
);

  typedef enum logic [1:0] {
    SDCR_DEV_IDLE,
    SDCR_DEV_RECV,
    SDCR_DEV_WAIT,
    SDCR_DEV_SEND
  } sdcr_dev_state_t;

  typedef struct packed {
    logic            clk_s1;
    logic            clk_s2;
    logic            clk_d;
    logic            cmd_s1;
    logic            cmd_s2;
    sdcr_dev_state_t state;
    logic [47:0]     sh;
    logic [5:0]      cnt;
    logic [15:0]     relative_card_address;
    logic            copy;
    logic            perm;
    logic            tmp;
    logic            inactive;
    logic            cmd_o;
    logic            cmd_oe;
  } sdcr_dev_regs_t;

  localparam sdcr_dev_regs_t DEV_RESET = '{
    state:    SDCR_DEV_IDLE,
    relative_card_address:      sdcr_pkg::RCA_RESET,
    copy:     sdcr_pkg::COPY_RESET,
    perm:     sdcr_pkg::PERM_RESET,
    tmp:      sdcr_pkg::TMP_RESET,
    cmd_o:    sdcr_pkg::CMD_RELEASED,
    default:  '0
  };

  sdcr_dev_regs_t r;
  sdcr_dev_regs_t n;
  logic           rise;
  logic           fall;
  logic [47:0]    frame;
  logic [5:0]     idx;
  logic [31:0]    arg;
  logic [31:0]    payload;
  logic           answer;
  logic [47:0]    csd_now;
  logic [47:0]    csd_new;

  // Low 48 bits of the card data register; constants outside the three flags
  function automatic logic [47:0] csd_low(input logic copy, input logic perm, input logic tmp);
    logic [47:0] c;
    c = 48'h0000_0000_0000;
    c[sdcr_pkg::CSD_ERASE_BIT]       = sdcr_pkg::ERASE_BLOCK_ENABLE_VAL;
    c[sdcr_pkg::CSD_SECTOR_LSB +: 7] = sdcr_pkg::SECTOR_SIZE_VAL;
    c[sdcr_pkg::CSD_R2W_LSB +: 3]    = sdcr_pkg::R2W_VAL;
    c[sdcr_pkg::CSD_WBL_LSB +: 4]    = sdcr_pkg::WRITE_BL_LEN_VAL;
    c[sdcr_pkg::CSD_WPART_BIT]       = sdcr_pkg::WPART_VAL;
    c[sdcr_pkg::CSD_FFG_BIT]         = sdcr_pkg::FFG_VAL;
    c[sdcr_pkg::CSD_COPY_BIT]        = copy;
    c[sdcr_pkg::CSD_PERM_BIT]        = perm;
    c[sdcr_pkg::CSD_TMP_BIT]         = tmp;
    c[sdcr_pkg::CSD_FF_LSB +: 2]     = sdcr_pkg::FIELD_A_VAL;
    // Checksum covers only the bits held here
    c[sdcr_pkg::CSD_CRC_LSB +: 7]    = sdcr_pkg::crc7(c[47:8]);
    c[sdcr_pkg::CSD_END_BIT]         = sdcr_pkg::END_BIT_VAL;
    return c;
  endfunction : csd_low

  always_comb begin
    n = r;

    // Link pins are foreign to clk_in
    n.clk_s1 = link.link_clk;
    n.clk_s2 = r.clk_s1;
    n.clk_d  = r.clk_s2;
    n.cmd_s1 = link.cmd;
    n.cmd_s2 = r.cmd_s1;

    rise    = r.clk_s2 & ~r.clk_d;
    fall    = ~r.clk_s2 & r.clk_d;
    frame   = {r.sh[46:0], r.cmd_s2};
    idx     = frame[45:40];
    arg     = frame[39:8];
    csd_now = csd_low(r.copy, r.perm, r.tmp);
    csd_new = csd_now;
    payload = 32'h0000_0000;
    answer  = 1'b0;

    case (r.state)
      SDCR_DEV_IDLE: begin
        // Nothing is heard once inactive; only a reset brings it back
        if (rise && !r.inactive && (r.cmd_s2 == 1'b0)) begin
          n.state = SDCR_DEV_RECV;
          n.sh    = 48'h0000_0000_0000;
          n.cnt   = 6'h01;
        end
      end

      SDCR_DEV_RECV: begin
        if (rise) begin
          n.sh  = frame;
          n.cnt = r.cnt + 6'h01;
          if (r.cnt == sdcr_pkg::CNT_LAST) begin
            n.state = SDCR_DEV_IDLE;
            n.cnt   = 6'h00;
            // Frames with a bad checksum or wrong direction draw no answer
            if (sdcr_pkg::frame_ok(frame, sdcr_pkg::DIR_HOST)) begin
              case (idx)
                sdcr_pkg::IDX_SET_RCA: begin
                  n.relative_card_address   = arg[sdcr_pkg::ARG_RCA_LSB +: 16];
                  payload = {arg[sdcr_pkg::ARG_RCA_LSB +: 16], 16'h0000};
                  answer  = 1'b1;
                end
                sdcr_pkg::IDX_READ_CSD: begin
                  payload = arg[sdcr_pkg::ARG_SEL_HIGH_BIT] ? {16'h0000, csd_now[47:32]} : csd_now[31:0];
                  answer  = 1'b1;
                end
                sdcr_pkg::IDX_PROGRAM_CSD: begin
                  // Once-only flags can be set but never cleared
                  n.copy  = r.copy | arg[sdcr_pkg::CSD_COPY_BIT];
                  n.perm  = r.perm | arg[sdcr_pkg::CSD_PERM_BIT];
                  n.tmp   = arg[sdcr_pkg::CSD_TMP_BIT];
                  csd_new = csd_low(n.copy, n.perm, n.tmp);
                  payload = csd_new[31:0];
                  answer  = 1'b1;
                end
                sdcr_pkg::IDX_ERASE: begin
                  payload = (arg == sdcr_pkg::ERASE_ONE_BLOCK) ? sdcr_pkg::STAT_ERASE_REFUSED : 32'h0000_0000;
                  answer  = 1'b1;
                end
                sdcr_pkg::IDX_INACTIVE: begin
                  n.inactive = 1'b1;
                end
                sdcr_pkg::IDX_DRIVER_STAGE: begin
                  // No drive-strength register; silently dropped
                  answer = 1'b0;
                end
                default: begin
                  answer = 1'b0;
                end
              endcase
              if (answer) begin
                n.sh    = sdcr_pkg::make_frame(sdcr_pkg::DIR_CARD, idx, payload);
                n.state = SDCR_DEV_WAIT;
              end
            end
          end
        end
      end

      SDCR_DEV_WAIT: begin
        // Gap lets the host release the line before we drive it
        if (fall) begin
          if (r.cnt == sdcr_pkg::NCR_LAST) begin
            n.cmd_oe = 1'b1;
            n.cmd_o  = r.sh[47];
            n.sh     = {r.sh[46:0], 1'b0};
            n.cnt    = 6'h01;
            n.state  = SDCR_DEV_SEND;
          end else begin
            n.cnt = r.cnt + 6'h01;
          end
        end
      end

      SDCR_DEV_SEND: begin
        if (fall) begin
          if (r.cnt == sdcr_pkg::CNT_FRAME) begin
            n.cmd_oe = 1'b0;
            n.cmd_o  = sdcr_pkg::CMD_RELEASED;
            n.cnt    = 6'h00;
            n.state  = SDCR_DEV_IDLE;
          end else begin
            n.cmd_o = r.sh[47];
            n.sh    = {r.sh[46:0], 1'b0};
            n.cnt   = r.cnt + 6'h01;
          end
        end
      end

      default: begin
        n = DEV_RESET;
      end
    endcase
  end

  // Power cycle is the only reset the card knows
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= DEV_RESET;
    end else begin
      r <= n;
    end
  end

  assign link.cmd_dev_o  = r.cmd_o;
  assign link.cmd_dev_oe = r.cmd_oe;
  assign rca_out          = r.relative_card_address;
  assign copy_out         = r.copy;
  assign perm_protect_out = r.perm;
  assign tmp_protect_out  = r.tmp;
  assign inactive_out     = r.inactive;

endmodule : sdcr_device

// ---- logic/sdcr_host.sv ----
// Host end: link clock divider, power-up clocks, command sender and response receiver
`timescale 1ns/1ps
module sdcr_host (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Power control
  input  wire logic        power_down_in,
  output logic             init_done_out,
  // Command request
  input  wire logic        cmd_valid_in,
  input  wire logic [5:0]  cmd_index_in,
  input  wire logic [31:0] cmd_arg_in,
  output logic             cmd_ready_out,
  output logic             cmd_refused_out,
  // Response
  output logic             rsp_valid_out,
  output logic [5:0]       rsp_index_out,
  output logic [31:0]      rsp_arg_out,
  output logic             rsp_crc_err_out,
  output logic             rsp_timeout_out,
  // Card bus
  sdcr_link_if.host        link
);

  typedef enum logic [2:0] {
    SDCR_HOST_INIT,
    SDCR_HOST_IDLE,
    SDCR_HOST_SEND,
    SDCR_HOST_WAIT,
    SDCR_HOST_RECV
  } sdcr_host_state_t;

  typedef struct packed {
    logic             cmd_s1;
    logic             cmd_s2;
    logic             link_clk;
    logic [2:0]       div;
    sdcr_host_state_t state;
    logic [47:0]      sh;
    logic [6:0]       cnt;
    logic             sel_high;
    logic             erase_single_ok;
    logic             cmd_o;
    logic             cmd_oe;
    logic             cmd_ready;
    logic             cmd_refused;
    logic             rsp_valid;
    logic [5:0]       rsp_index;
    logic [31:0]      rsp_arg;
    logic             rsp_crc_err;
    logic             rsp_timeout;
    logic             init_done;
  } sdcr_host_regs_t;

  localparam sdcr_host_regs_t HOST_RESET = '{
    state:   SDCR_HOST_INIT,
    cmd_o:   sdcr_pkg::CMD_RELEASED,
    cmd_oe:  1'b1,
    default: '0
  };

  sdcr_host_regs_t r;
  sdcr_host_regs_t n;
  logic            tick;
  logic            rise_t;
  logic            fall_t;
  logic [47:0]     frame;

  always_comb begin
    n = r;
    n.cmd_s1      = link.cmd;
    n.cmd_s2      = r.cmd_s1;
    n.cmd_refused = 1'b0;
    n.rsp_valid   = 1'b0;
    n.rsp_timeout = 1'b0;

    tick   = (r.div == sdcr_pkg::LINK_HALF_LAST);
    rise_t = tick & ~r.link_clk;
    fall_t = tick & r.link_clk;
    frame  = {r.sh[46:0], r.cmd_s2};
    n.div  = tick ? 3'h0 : r.div + 3'h1;
    if (tick) begin
      n.link_clk = ~r.link_clk;
    end

    case (r.state)
      SDCR_HOST_INIT: begin
        // Command held high through the power-up clocks
        n.cmd_oe = 1'b1;
        n.cmd_o  = sdcr_pkg::CMD_RELEASED;
        if (rise_t) begin
          n.cnt = r.cnt + 7'h01;
          if (r.cnt == sdcr_pkg::INIT_LAST) begin
            n.cnt       = 7'h00;
            n.state     = SDCR_HOST_IDLE;
            n.cmd_ready = 1'b1;
            n.init_done = 1'b1;
          end
        end
      end

      SDCR_HOST_IDLE: begin
        // Card releases a few cycles after this fall, so skip it before driving again
        if (fall_t && (r.cnt != 7'h00)) begin
          n.cnt       = 7'h00;
          n.cmd_ready = 1'b1;
        end else if (fall_t) begin
          n.cmd_oe = 1'b1;
          n.cmd_o  = sdcr_pkg::CMD_RELEASED;
        end
        if (cmd_valid_in && r.cmd_ready) begin
          // Single-block erase only once the card has shown it allows it
          if ((cmd_index_in == sdcr_pkg::IDX_ERASE) && (cmd_arg_in == sdcr_pkg::ERASE_ONE_BLOCK)
              && !r.erase_single_ok) begin
            n.cmd_refused = 1'b1;
          end else begin
            n.sh        = sdcr_pkg::make_frame(sdcr_pkg::DIR_HOST, cmd_index_in, cmd_arg_in);
            n.sel_high  = cmd_arg_in[sdcr_pkg::ARG_SEL_HIGH_BIT] && (cmd_index_in == sdcr_pkg::IDX_READ_CSD);
            n.cmd_ready = 1'b0;
            n.cnt       = 7'h00;
            n.state     = SDCR_HOST_SEND;
          end
        end
      end

      SDCR_HOST_SEND: begin
        if (fall_t) begin
          if (r.cnt == {1'b0, sdcr_pkg::CNT_FRAME}) begin
            n.cmd_oe = 1'b0;
            n.cnt    = 7'h00;
            n.state  = SDCR_HOST_WAIT;
          end else begin
            n.cmd_oe = 1'b1;
            n.cmd_o  = r.sh[47];
            n.sh     = {r.sh[46:0], 1'b0};
            n.cnt    = r.cnt + 7'h01;
          end
        end
      end

      SDCR_HOST_WAIT: begin
        if (rise_t) begin
          if (r.cmd_s2 == 1'b0) begin
            n.sh    = 48'h0000_0000_0000;
            n.cnt   = 7'h01;
            n.state = SDCR_HOST_RECV;
          end else if (r.cnt == sdcr_pkg::RSP_TIMEOUT - 7'h01) begin
            n.rsp_timeout = 1'b1;
            n.cmd_ready   = 1'b1;
            n.cnt         = 7'h00;
            n.state       = SDCR_HOST_IDLE;
          end else begin
            n.cnt = r.cnt + 7'h01;
          end
        end
      end

      SDCR_HOST_RECV: begin
        if (rise_t) begin
          n.sh  = frame;
          n.cnt = r.cnt + 7'h01;
          if (r.cnt == {1'b0, sdcr_pkg::CNT_LAST}) begin
            n.rsp_valid   = 1'b1;
            n.rsp_index   = frame[45:40];
            n.rsp_arg     = frame[39:8];
            n.rsp_crc_err = !sdcr_pkg::frame_ok(frame, sdcr_pkg::DIR_CARD);
            if (r.sel_high && sdcr_pkg::frame_ok(frame, sdcr_pkg::DIR_CARD)) begin
              n.erase_single_ok = frame[8 + sdcr_pkg::ERASE_IN_HIGH];
            end
            // Card still owns the line until its next falling edge
            n.cnt       = 7'h01;
            n.state     = SDCR_HOST_IDLE;
          end
        end
      end

      default: begin
        n = HOST_RESET;
      end
    endcase

    // Lines released and clock parked low so no current feeds the card
    if (power_down_in) begin
      n          = HOST_RESET;
      n.cmd_s1   = link.cmd;
      n.cmd_s2   = r.cmd_s1;
      n.cmd_oe   = 1'b0;
      n.link_clk = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= HOST_RESET;
    end else begin
      r <= n;
    end
  end

  assign link.link_clk    = r.link_clk;
  assign link.cmd_host_o  = r.cmd_o;
  assign link.cmd_host_oe = r.cmd_oe;
  assign init_done_out    = r.init_done;
  assign cmd_ready_out    = r.cmd_ready;
  assign cmd_refused_out  = r.cmd_refused;
  assign rsp_valid_out    = r.rsp_valid;
  assign rsp_index_out    = r.rsp_index;
  assign rsp_arg_out      = r.rsp_arg;
  assign rsp_crc_err_out  = r.rsp_crc_err;
  assign rsp_timeout_out  = r.rsp_timeout;

endmodule : sdcr_host

// ---- testbench/sdcr_link_asserts.sv ----
// Wire checks on the card bus between host and card ends
`timescale 1ns/1ps
module sdcr_link_asserts (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rstn_in,
  // Card bus
  input wire logic link_clk,
  input wire logic cmd_host_o,
  input wire logic cmd_host_oe,
  input wire logic cmd_dev_o,
  input wire logic cmd_dev_oe,
  input wire logic cmd
);
  logic        link_d;
  logic [6:0]  rises;
  logic [9:0]  oe_cnt;
  logic [47:0] shreg;

  // Rise count saturates so a long run cannot wrap back under the init limit
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link_d <= 1'b0;
      rises  <= 7'h00;
      oe_cnt <= 10'h000;
      shreg  <= 48'h0000_0000_0000;
    end else begin
      link_d <= link_clk;
      oe_cnt <= cmd_dev_oe ? oe_cnt + 10'h001 : 10'h000;
      if (link_clk && !link_d) begin
        shreg <= {shreg[46:0], cmd};
        if (rises != 7'h7f) begin
          rises <= rises + 7'h01;
        end
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_high_run;
    $stable(link_clk) [*7] ##1 $fell(link_clk);
  endsequence
  sequence s_dev_start;
    !link_clk && !cmd_dev_o && !$past(cmd_host_oe, 8);
  endsequence

  property p_link_high;
    $rose(link_clk) |=> s_high_run;
  endproperty
  property p_init_cmd_high;
    (rises < 7'h4a) |-> cmd;
  endproperty
  property p_no_clash;
    !(cmd_host_oe && cmd_dev_oe);
  endproperty
  property p_host_bit_on_fall;
    ($changed(cmd_host_o) && cmd_host_oe && $past(cmd_host_oe)) |-> $fell(link_clk);
  endproperty
  property p_dev_bit_when_low;
    ($changed(cmd_dev_o) && cmd_dev_oe && $past(cmd_dev_oe)) |-> !link_clk;
  endproperty
  property p_dev_start;
    $rose(cmd_dev_oe) |-> s_dev_start;
  endproperty
  property p_dev_end_bit;
    $fell(cmd_dev_oe) |-> $past(cmd_dev_o);
  endproperty
  property p_dev_frame_len;
    $fell(cmd_dev_oe) |-> (oe_cnt == 10'h300);
  endproperty
  property p_dev_frame_fields;
    $fell(cmd_dev_oe) |-> (shreg[47:46] == 2'h0) && shreg[0];
  endproperty

  a_link_high: assert property (p_link_high) else $error("link clock high phase not 8 cycles");
  a_init_cmd_high: assert property (p_init_cmd_high) else $error("command line low before 74 clocks");
  a_no_clash: assert property (p_no_clash) else $error("both ends drive the command line");
  a_host_bit_on_fall: assert property (p_host_bit_on_fall) else $error("host bit not on falling link edge");
  a_dev_bit_when_low: assert property (p_dev_bit_when_low) else $error("card bit changes with link high");
  a_dev_start: assert property (p_dev_start) else $error("card answer start malformed");
  a_dev_end_bit: assert property (p_dev_end_bit) else $error("card answer end bit not one");
  a_dev_frame_len: assert property (p_dev_frame_len) else $error("card answer not 48 bits long");
  a_dev_frame_fields: assert property (p_dev_frame_fields) else $error("card answer framing wrong");
endmodule : sdcr_link_asserts

// ---- testbench/tb_sd_card_regs_powerup.sv ----
// Self-checking bench: host and card ends joined over the card bus
`timescale 1ns/1ps
module tb_sd_card_regs_powerup;
  logic        clk_in;
  logic        rstn_in;
  logic        dev_rstn;
  logic        power_down;
  logic        cmd_valid;
  logic [5:0]  cmd_index;
  logic [31:0] cmd_arg;
  logic        init_done;
  logic        cmd_ready;
  logic        cmd_refused;
  logic        rsp_valid;
  logic [5:0]  rsp_index;
  logic [31:0] rsp_arg;
  logic        rsp_crc_err;
  logic        rsp_timeout;
  logic [15:0] relative_card_address;
  logic        copy;
  logic        perm;
  logic        tmp;
  logic        inactive;
  logic [1:0]  kind;
  logic [31:0] got;
  logic [47:0] f;
  logic [31:0] pargs [4] = '{32'h0000_1000, 32'h0000_0000, 32'h0000_6000, 32'h0000_0000};
  logic [2:0]  pflags [4] = '{3'h1, 3'h0, 3'h6, 3'h6};
  int          n_fail;
  int          compares;

  sdcr_link_if sdcr_link_if_inst ();

  sdcr_host sdcr_host_inst (
    .clk_in          (clk_in),
    .rstn_in         (rstn_in),
    .power_down_in   (power_down),
    .init_done_out   (init_done),
    .cmd_valid_in    (cmd_valid),
    .cmd_index_in    (cmd_index),
    .cmd_arg_in      (cmd_arg),
    .cmd_ready_out   (cmd_ready),
    .cmd_refused_out (cmd_refused),
    .rsp_valid_out   (rsp_valid),
    .rsp_index_out   (rsp_index),
    .rsp_arg_out     (rsp_arg),
    .rsp_crc_err_out (rsp_crc_err),
    .rsp_timeout_out (rsp_timeout),
    .link            (sdcr_link_if_inst.host)
  );

  sdcr_device sdcr_device_inst (
    .clk_in           (clk_in),
    .rstn_in          (dev_rstn),
    .link             (sdcr_link_if_inst.device),
    .rca_out          (relative_card_address),
    .copy_out         (copy),
    .perm_protect_out (perm),
    .tmp_protect_out  (tmp),
    .inactive_out     (inactive)
  );

  sdcr_link_asserts sdcr_link_asserts_inst (
    .clk_in      (clk_in),
    .rstn_in     (rstn_in),
    .link_clk    (sdcr_link_if_inst.link_clk),
    .cmd_host_o  (sdcr_link_if_inst.cmd_host_o),
    .cmd_host_oe (sdcr_link_if_inst.cmd_host_oe),
    .cmd_dev_o   (sdcr_link_if_inst.cmd_dev_o),
    .cmd_dev_oe  (sdcr_link_if_inst.cmd_dev_oe),
    .cmd         (sdcr_link_if_inst.cmd)
  );

  // Own copy of the card data layout, so expectations never reuse design code
  function automatic logic [47:0] csd(input logic c, input logic p, input logic t);
    logic [39:0] h;
    logic [6:0]  r;
    h = {2'h0, 7'h7f, 10'h000, 3'h2, 4'h9, 1'b0, 5'h00, 1'b0, c, p, t, 4'h0};
    r = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      r = {r[5:0], 1'b0} ^ ((h[i] ^ r[6]) ? 7'h09 : 7'h00);
    end
    return {h, r, 1'b1};
  endfunction : csd

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic wait_init();
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 4000) begin
      @(posedge clk_in);
      n++;
    end
    chk("init_done", {31'h0, init_done}, 32'h1);
    chk("init_long", {31'h0, n >= 1168}, 32'h1);
  endtask : wait_init

  // Kind: 0 answer, 1 timeout, 2 refused, 3 hung
  task automatic run(input logic [5:0] idx, input logic [31:0] arg, input logic [1:0] ek, input logic [31:0] ea);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(posedge clk_in);
      n++;
    end
    cmd_valid <= 1'b1;
    cmd_index <= idx;
    cmd_arg   <= arg;
    @(posedge clk_in);
    cmd_valid <= 1'b0;
    kind = 2'h3;
    n = 0;
    while (kind == 2'h3 && n < 4000) begin
      @(posedge clk_in);
      n++;
      if (rsp_valid === 1'b1) kind = 2'h0;
      if (rsp_timeout === 1'b1) kind = 2'h1;
      if (cmd_refused === 1'b1) kind = 2'h2;
    end
    @(posedge clk_in);
    chk("kind", {30'h0, kind}, {30'h0, ek});
    if (ek == 2'h0) begin
      chk("rsp_arg", rsp_arg, ea);
      chk("rsp_index", {26'h0, rsp_index}, {26'h0, idx});
      chk("crc_err", {31'h0, rsp_crc_err}, 32'h0);
    end
  endtask : run

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // Whole run is well under half a millisecond
  initial begin
    #600000;
    n_fail++;
    close_out();
  end

  initial begin
    rstn_in    = 1'b0;
    dev_rstn   = 1'b0;
    power_down = 1'b0;
    cmd_valid  = 1'b0;
    cmd_index  = 6'h00;
    cmd_arg    = 32'h0000_0000;
    n_fail     = 0;
    compares   = 0;
    repeat (3) @(posedge clk_in);
    rstn_in  <= 1'b1;
    dev_rstn <= 1'b1;
    chk("rca", {16'h0, relative_card_address}, 32'h0);
    chk("flags", {28'h0, copy, perm, tmp, inactive}, 32'h0);
    wait_init();
    $display("test power-up done");
    f = csd(1'b0, 1'b0, 1'b0);
    run(6'h09, 32'h0000_0000, 2'h0, f[31:0]);
    run(6'h09, 32'h0000_0001, 2'h0, {16'h0, f[47:32]});
    run(6'h26, 32'h0000_0001, 2'h2, 32'h0);
    chk("ready", {31'h0, cmd_ready}, 32'h1);
    run(6'h26, 32'h0000_0002, 2'h0, 32'h0);
    $display("test card data done");
    run(6'h03, 32'ha5c3_0000, 2'h0, 32'ha5c3_0000);
    chk("rca", {16'h0, relative_card_address}, 32'h0000_a5c3);
    run(6'h03, 32'h5a3c_0000, 2'h0, 32'h5a3c_0000);
    run(6'h04, 32'hffff_ffff, 2'h1, 32'h0);
    chk("rca", {16'h0, relative_card_address}, 32'h0000_5a3c);
    $display("test address done");
    for (int i = 0; i < 4; i++) begin
      f = csd(pflags[i][2], pflags[i][1], pflags[i][0]);
      run(6'h1b, pargs[i], 2'h0, f[31:0]);
      chk("flags", {29'h0, copy, perm, tmp}, {29'h0, pflags[i]});
    end
    run(6'h09, 32'h0000_0000, 2'h0, f[31:0]);
    $display("test protect done");
    run(6'h0f, 32'h0000_0000, 2'h1, 32'h0);
    chk("inactive", {31'h0, inactive}, 32'h1);
    run(6'h09, 32'h0000_0000, 2'h1, 32'h0);
    run(6'h03, 32'h1111_0000, 2'h1, 32'h0);
    chk("rca", {16'h0, relative_card_address}, 32'h0000_5a3c);
    $display("test inactive done");
    // Enter power-down with the link low so its phase is not cut short
    @(negedge sdcr_link_if_inst.link_clk);
    @(posedge clk_in);
    power_down <= 1'b1;
    repeat (40) @(posedge clk_in);
    chk("link_clk", {31'h0, sdcr_link_if_inst.link_clk}, 32'h0);
    chk("host_oe", {31'h0, sdcr_link_if_inst.cmd_host_oe}, 32'h0);
    dev_rstn <= 1'b0;
    @(posedge clk_in);
    dev_rstn   <= 1'b1;
    power_down <= 1'b0;
    @(posedge clk_in);
    chk("flags", {28'h0, copy, perm, tmp, inactive}, 32'h0);
    chk("rca", {16'h0, relative_card_address}, 32'h0);
    wait_init();
    f = csd(1'b0, 1'b0, 1'b0);
    run(6'h09, 32'h0000_0000, 2'h0, f[31:0]);
    $display("test power cycle done");
    close_out();
  end
endmodule : tb_sd_card_regs_powerup
